// ### core/wac_pkg.sv
// Package: constants and carriers for the walk attribute control registers
`default_nettype none
package wac_pkg;
   localparam int WAC_W = 64;
   // System register encoding fields
   localparam logic [1:0] ENC_OP0 = 2'h3;
   localparam logic [2:0] ENC_OP1_L1 = 3'h0;
   localparam logic [2:0] ENC_OP1_L2 = 3'h4;
   localparam logic [2:0] ENC_OP1_ALIAS = 3'h5;
   localparam logic [2:0] ENC_OP1_L3 = 3'h6;
   localparam logic [3:0] ENC_CRN = 4'hF;
   localparam logic [3:0] ENC_CRM = 4'h7;
   localparam logic [2:0] ENC_OP2_MAIN = 3'h0;
   localparam logic [2:0] ENC_OP2_S2 = 3'h1;
   // Field positions
   localparam int LOWER_ATTR0_EN_BIT = 0;
   localparam int LOWER_ATTR1_EN_BIT = 1;
   localparam int UPPER_ATTR0_EN_BIT = 4;
   localparam int UPPER_ATTR1_EN_BIT = 5;
   localparam int LOWER_ATTR0_VAL_BIT = 8;
   localparam int LOWER_ATTR1_VAL_BIT = 9;
   localparam int UPPER_ATTR0_VAL_BIT = 12;
   localparam int UPPER_ATTR1_VAL_BIT = 13;
   // Writable bits; everything else reads zero
   localparam logic [63:0] DUAL_MASK = 64'h0000_0000_0000_3333;
   localparam logic [63:0] SINGLE_MASK = 64'h0000_0000_0000_0303;
   localparam logic [63:0] RESET_VAL = 64'h0000_0000_0000_0000;
   // Exception levels
   localparam logic [1:0] EL0 = 2'h0;
   localparam logic [1:0] EL1 = 2'h1;
   localparam logic [1:0] EL2 = 2'h2;
   localparam logic [1:0] EL3 = 2'h3;

   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
      logic [63:0] wdata;
   } wac_req_s;

   typedef struct packed {
      logic valid;
      logic [1:0] el;
      logic upper_base;
      logic stage2;
   } wac_walk_s;

   typedef enum logic [4:0] {
      WAC_SEL_NONE = 5'h01,
      WAC_SEL_L1 = 5'h02,
      WAC_SEL_L2 = 5'h04,
      WAC_SEL_L3 = 5'h08,
      WAC_SEL_S2 = 5'h10
   } wac_sel_e;
endpackage
`default_nettype wire

// ### core/wac_reg.sv
// One masked 64-bit control register with reset and write port
`default_nettype none
module wac_reg
   import wac_pkg::*;
#(
   parameter logic [63:0] MASK = 64'h0000_0000_0000_3333
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic wr,
   input wire logic [63:0] wdata,
   output logic [63:0] q
);
   logic [63:0] next_q;

   always_comb
   begin
      next_q = q;
      if (wr)
      begin
         next_q = wdata & MASK; // (R24)
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         q <= RESET_VAL; // (R25)
      end
      else
      begin
         q <= next_q;
      end
   end
endmodule // wac_reg
`default_nettype wire

// ### core/wac_attr_pick.sv
// Selects one attribute bit from an enable and a value
`default_nettype none
module wac_attr_pick
(
   input wire logic en,
   input wire logic val,
   output logic attr
);
   // Clear enable forces the line low
   assign attr = en & val; // (R05) (R06)
endmodule // wac_attr_pick
`default_nettype wire

// ### core/wac_top.sv
// Walk attribute control register bank and walk attribute driver
// ======================================================================
// What this block does
// (R01) Upper base walk: bit13 drives attr1 if bit5
// (R02) Upper base walk: bit12 drives attr0 if bit4
// (R03) Lower base walk: bit9 drives attr1 if bit1
// (R04) Lower base walk: bit8 drives attr0 if bit0
// (R05) Attr1 low when its enable clear
// (R06) Attr0 low when its enable clear
// (R07) Registers 64 bits, dual reserved fields zero
// (R08) Each level register governs its own regime
// (R09) Single registers: bit9 drives attr1 if bit1
// (R10) Single registers: bit8 drives attr0 if bit0
// (R11) Stage 2 register only for enabled stage2
// (R12) No effect unless attribute support configured
// (R13) Level 2 with host mode: level1 reaches level2
// (R14) Alias undefined unless host mode set
// (R15) Level 1 traps also apply to alias
// (R16) Level 1 at 3,0,c15,c7,0
// (R17) Level 2 at 3,4,c15,c7,0
// (R18) Alias at 3,5,15,7,0
// (R19) Level 3 at 3,6,c15,c7,0
// (R20) Stage 2 at 3,4,c15,c7,1
// (R21) Level 2 register only at levels 2,3
// (R22) Level 3 register only at level 3
// (R23) Stage 2 register only at levels 2,3
// (R24) Reserved bits read zero, ignore writes
// (R25) Enables and values reset to zero
`default_nettype none
module wac_top
   import wac_pkg::*;
#(
   parameter bit ATTR_SUPPORT = 1'b1
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] cur_el,
   input wire logic host_hypervisor_mode,
   input wire logic level1_trap,
   input wire wac_pkg::wac_req_s req,
   output logic rsp_valid,
   output logic [63:0] rsp_rdata,
   output logic rsp_undef,
   output logic rsp_trap,
   input wire wac_pkg::wac_walk_s walk,
   output logic [1:0] page_hw_attribute_bits,
   output logic [63:0] walk_attr_ctrl_level1_q,
   output logic [63:0] walk_attr_ctrl_level2_q,
   output logic [63:0] walk_attr_ctrl_level3_q,
   output logic [63:0] stage2_walk_attr_ctrl_q
);
   import wac_pkg::*;

   // ======================================================================
   // Decode
   wac_sel_e sel;
   logic enc_hit;
   logic undef_c;
   logic trap_c;
   logic alias_hit;
   logic hit_l1;
   logic hit_l2;
   logic hit_l3;
   logic hit_s2;
   logic el_high;

   assign enc_hit = req.valid && req.op0 == ENC_OP0 && req.crn == ENC_CRN && req.crm == ENC_CRM;
   assign alias_hit = enc_hit && req.op1 == ENC_OP1_ALIAS && req.op2 == ENC_OP2_MAIN; // (R18)
   assign hit_l1 = enc_hit && req.op1 == ENC_OP1_L1 && req.op2 == ENC_OP2_MAIN; // (R16)
   assign hit_l2 = enc_hit && req.op1 == ENC_OP1_L2 && req.op2 == ENC_OP2_MAIN; // (R17)
   assign hit_l3 = enc_hit && req.op1 == ENC_OP1_L3 && req.op2 == ENC_OP2_MAIN; // (R19)
   assign hit_s2 = enc_hit && req.op1 == ENC_OP1_L2 && req.op2 == ENC_OP2_S2; // (R20)
   // Level 2 and stage 2 registers share one access check
   assign el_high = cur_el == EL2 || cur_el == EL3;

   always_comb
   begin
      sel = WAC_SEL_NONE;
      undef_c = 1'b0;
      trap_c = 1'b0;
      if (enc_hit)
      begin
         if (hit_l1)
         begin
            if (cur_el == EL0)
            begin
               undef_c = 1'b1;
            end
            else if (cur_el == EL2 && host_hypervisor_mode)
            begin
               sel = WAC_SEL_L2; // (R13)
            end
            else if (cur_el == EL1 && level1_trap)
            begin
               trap_c = 1'b1;
            end
            else
            begin
               sel = WAC_SEL_L1;
            end
         end
         else if (alias_hit)
         begin
            // Alias only reachable from the higher levels
            if (!host_hypervisor_mode || cur_el == EL0 || cur_el == EL1)
            begin
               undef_c = 1'b1; // (R14)
            end
            else if (level1_trap && cur_el == EL2)
            begin
               trap_c = 1'b1; // (R15)
            end
            else
            begin
               sel = WAC_SEL_L1; // (R14)
            end
         end
         else if (hit_l2)
         begin
            if (el_high)
            begin
               sel = WAC_SEL_L2; // (R21)
            end
            else
            begin
               undef_c = 1'b1;
            end
         end
         else if (hit_s2)
         begin
            if (el_high)
            begin
               sel = WAC_SEL_S2; // (R23)
            end
            else
            begin
               undef_c = 1'b1;
            end
         end
         else if (hit_l3)
         begin
            if (cur_el == EL3)
            begin
               sel = WAC_SEL_L3; // (R22)
            end
            else
            begin
               undef_c = 1'b1;
            end
         end
         else
         begin
            undef_c = 1'b1;
         end
      end
      else if (req.valid)
      begin
         undef_c = 1'b1;
      end
   end

   // ======================================================================
   // Register storage
   logic wr_go;
   logic wr_l1;
   logic wr_l2;
   logic wr_l3;
   logic wr_s2;

   // Refused accesses leave sel at none, so no strobe fires
   assign wr_go = req.valid && req.write;
   assign wr_l1 = wr_go && sel == WAC_SEL_L1;
   assign wr_l2 = wr_go && sel == WAC_SEL_L2;
   assign wr_l3 = wr_go && sel == WAC_SEL_L3;
   assign wr_s2 = wr_go && sel == WAC_SEL_S2;

   wac_reg #(.MASK(DUAL_MASK)) u_l1 // (R07)
   (
      .mclk(mclk),
      .rst(rst),
      .wr(wr_l1),
      .wdata(req.wdata),
      .q(walk_attr_ctrl_level1_q)
   );

   wac_reg #(.MASK(DUAL_MASK)) u_l2
   (
      .mclk(mclk),
      .rst(rst),
      .wr(wr_l2),
      .wdata(req.wdata),
      .q(walk_attr_ctrl_level2_q)
   );

   wac_reg #(.MASK(SINGLE_MASK)) u_l3 // (R10)
   (
      .mclk(mclk),
      .rst(rst),
      .wr(wr_l3),
      .wdata(req.wdata),
      .q(walk_attr_ctrl_level3_q)
   );

   wac_reg #(.MASK(SINGLE_MASK)) u_s2
   (
      .mclk(mclk),
      .rst(rst),
      .wr(wr_s2),
      .wdata(req.wdata),
      .q(stage2_walk_attr_ctrl_q)
   );

   // ======================================================================
   // Read answer, registered one cycle after the request
   logic next_rsp_valid;
   logic [63:0] next_rsp_rdata;
   logic next_rsp_undef;
   logic next_rsp_trap;

   always_comb
   begin
      next_rsp_valid = req.valid;
      next_rsp_undef = undef_c;
      next_rsp_trap = trap_c;
      next_rsp_rdata = 64'h0000_0000_0000_0000;
      if (!req.write)
      begin
         case (sel)
            WAC_SEL_L1: next_rsp_rdata = walk_attr_ctrl_level1_q;
            WAC_SEL_L2: next_rsp_rdata = walk_attr_ctrl_level2_q;
            WAC_SEL_L3: next_rsp_rdata = walk_attr_ctrl_level3_q;
            WAC_SEL_S2: next_rsp_rdata = stage2_walk_attr_ctrl_q;
            default: next_rsp_rdata = 64'h0000_0000_0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rsp_valid <= 1'b0;
         rsp_rdata <= 64'h0000_0000_0000_0000;
         rsp_undef <= 1'b0;
         rsp_trap <= 1'b0;
      end
      else
      begin
         rsp_valid <= next_rsp_valid;
         rsp_rdata <= next_rsp_rdata;
         rsp_undef <= next_rsp_undef;
         rsp_trap <= next_rsp_trap;
      end
   end

   // ======================================================================
   // Walk attribute selection
   logic [63:0] walk_reg;
   logic en1;
   logic en0;
   logic val1;
   logic val0;
   logic [1:0] attr_c;
   logic [1:0] next_attr;
   logic single_reg;

   assign single_reg = walk.stage2 || walk.el == EL3;

   always_comb
   begin
      walk_reg = 64'h0000_0000_0000_0000;
      if (walk.stage2)
      begin
         // Stage 2 walks only exist in the level 1 regime
         if (walk.el == EL1 || walk.el == EL0)
         begin
            walk_reg = stage2_walk_attr_ctrl_q; // (R11)
         end
      end
      else
      begin
         case (walk.el) // (R08)
            EL0: walk_reg = walk_attr_ctrl_level1_q;
            EL1: walk_reg = walk_attr_ctrl_level1_q;
            EL2: walk_reg = walk_attr_ctrl_level2_q;
            EL3: walk_reg = walk_attr_ctrl_level3_q;
            default: walk_reg = 64'h0000_0000_0000_0000;
         endcase
      end
      // Single registers ignore the base choice
      if (walk.upper_base && !single_reg)
      begin
         en1 = walk_reg[UPPER_ATTR1_EN_BIT]; // (R01)
         val1 = walk_reg[UPPER_ATTR1_VAL_BIT]; // (R01)
         en0 = walk_reg[UPPER_ATTR0_EN_BIT]; // (R02)
         val0 = walk_reg[UPPER_ATTR0_VAL_BIT]; // (R02)
      end
      else
      begin
         en1 = walk_reg[LOWER_ATTR1_EN_BIT]; // (R03) (R09)
         val1 = walk_reg[LOWER_ATTR1_VAL_BIT]; // (R03) (R09)
         en0 = walk_reg[LOWER_ATTR0_EN_BIT]; // (R04) (R10)
         val0 = walk_reg[LOWER_ATTR0_VAL_BIT]; // (R04) (R10)
      end
   end

   wac_attr_pick u_pick1
   (
      .en(en1),
      .val(val1),
      .attr(attr_c[1])
   );

   wac_attr_pick u_pick0
   (
      .en(en0),
      .val(val0),
      .attr(attr_c[0])
   );

   always_comb
   begin
      next_attr = 2'h0;
      if (walk.valid && ATTR_SUPPORT)
      begin
         next_attr = attr_c; // (R12)
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         page_hw_attribute_bits <= 2'h0;
      end
      else
      begin
         page_hw_attribute_bits <= next_attr;
      end
   end
endmodule // wac_top
`default_nettype wire

// ### verif/wac_assertions.sv
// Checker: port-level assertions for the walk attribute register bank
`default_nettype none
module wac_assertions
   import wac_pkg::*;
#(
   parameter bit ATTR_SUPPORT = 1'b1
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] cur_el,
   input wire logic level1_trap,
   input wire wac_pkg::wac_req_s req,
   input wire logic rsp_valid,
   input wire logic rsp_undef,
   input wire wac_pkg::wac_walk_s walk,
   input wire logic [1:0] page_hw_attribute_bits,
   input wire logic [63:0] walk_attr_ctrl_level1_q,
   input wire logic [63:0] walk_attr_ctrl_level2_q,
   input wire logic [63:0] walk_attr_ctrl_level3_q,
   input wire logic [63:0] stage2_walk_attr_ctrl_q
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   function automatic logic [1:0] pr(input logic [63:0] q, input logic up);
      return !ATTR_SUPPORT ? 2'h0 : up ? {q[5] & q[13], q[4] & q[12]} : {q[1] & q[9], q[0] & q[8]};
   endfunction
   // ==================================================================
   // Sequences
   sequence s_l1_write;
      req.valid && req.write && req.op0 == ENC_OP0 && req.op1 == ENC_OP1_L1 && req.crn == ENC_CRN
         && req.crm == ENC_CRM && req.op2 == ENC_OP2_MAIN && cur_el == EL1 && !level1_trap ##1 rsp_valid;
   endsequence
   sequence s_walk(logic ok);
      walk.valid && ok;
   endsequence
   // ==================================================================
   // Properties
   a_l1_write:
   assert property (s_l1_write |-> walk_attr_ctrl_level1_q == ($past(req.wdata) & DUAL_MASK)) else $error("l1 write");
   a_idle_attr:
   assert property (!walk.valid |=> page_hw_attribute_bits == 2'h0) else $error("idle attr");
   a_l1_upper:
   assert property (s_walk(walk.el == EL1 && walk.upper_base && !walk.stage2)
      |=> page_hw_attribute_bits == pr($past(walk_attr_ctrl_level1_q), 1'b1)) else $error("upper attr");
   a_l1_lower:
   assert property (s_walk(!walk.el[1] && !walk.upper_base && !walk.stage2)
      |=> page_hw_attribute_bits == pr($past(walk_attr_ctrl_level1_q), 1'b0)) else $error("lower attr");
   a_l3_pair:
   assert property (s_walk(walk.el == EL3 && !walk.stage2)
      |=> page_hw_attribute_bits == pr($past(walk_attr_ctrl_level3_q), 1'b0)) else $error("l3 attr");
   a_s2_pair:
   assert property (s_walk(!walk.el[1] && walk.stage2)
      |=> page_hw_attribute_bits == pr($past(stage2_walk_attr_ctrl_q), 1'b0)) else $error("s2 attr");
   a_s2_high_el:
   assert property (s_walk(walk.el[1] && walk.stage2) |=> page_hw_attribute_bits == 2'h0) else $error("s2 el");
   a_undef_el0:
   assert property (req.valid && cur_el == EL0 |=> rsp_valid && rsp_undef) else $error("el0 access");
   a_reserved_zero:
   assert property ((walk_attr_ctrl_level1_q & ~DUAL_MASK) == 64'h0 && (walk_attr_ctrl_level3_q & ~SINGLE_MASK) == 64'h0
      && (stage2_walk_attr_ctrl_q & ~SINGLE_MASK) == 64'h0
      && (walk_attr_ctrl_level2_q & ~DUAL_MASK) == 64'h0) else $error("reserved bits");
endmodule // wac_assertions
`default_nettype wire

// ### verif/wac_walker.sv
// Partner: table walker model issuing one walk access at a time
`default_nettype none
module wac_walker
   import wac_pkg::*;
(
   input wire logic mclk,
   output var wac_pkg::wac_walk_s walk
);
   timeunit 1ns;
   timeprecision 1ps;
   initial walk = '0;
   // Released fields are inverted so stale values never look valid
   task automatic issue(input logic [1:0] el, input logic up, input logic s2);
      @(posedge mclk);
      #1 walk = '{valid: 1'b1, el: el, upper_base: up, stage2: s2};
      @(posedge mclk);
      #1 walk = ~walk;
   endtask
endmodule // wac_walker
`default_nettype wire

// ### verif/walk_attribute_ctrl_regs_tb_top.sv
// Testbench: register access and walk attribute scenarios
`default_nettype none
module walk_attribute_ctrl_regs_tb_top
   import wac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] cur_el = EL3;
   logic hm = 1'b0;
   logic trp = 1'b0;
   logic [3:0] crm_use = ENC_CRM;
   wac_req_s req = '0;
   wac_walk_s walk;
   logic rv, ru, rt;
   logic [1:0] attrs;
   logic [63:0] rdata, rd;
   int fails = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [2:0] op1s [5] = '{ENC_OP1_L1, ENC_OP1_L2, ENC_OP1_L3, ENC_OP1_L2, ENC_OP1_ALIAS};
   logic [63:0] pats [6] = '{64'h3333, 64'h3300, 64'h0033, 64'h3311, 64'h3322, 64'h2211};
   always #4 mclk = ~mclk;
   wac_top u_dut (.mclk(mclk), .rst(rst), .cur_el(cur_el), .host_hypervisor_mode(hm), .level1_trap(trp),
      .req(req), .rsp_valid(rv), .rsp_rdata(rdata), .rsp_undef(ru), .rsp_trap(rt), .walk(walk),
      .page_hw_attribute_bits(attrs), .walk_attr_ctrl_level1_q(), .walk_attr_ctrl_level2_q(),
      .walk_attr_ctrl_level3_q(), .stage2_walk_attr_ctrl_q());
   wac_walker u_walker (.mclk(mclk), .walk(walk));
   // ==================================================================
   // Tasks
   task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_attr(input logic [1:0] got, input logic [1:0] exp);
      chk_word({62'h0, got}, {62'h0, exp});
   endtask
   // Register index r: 0 level1, 1 level2, 2 level3, 3 stage2, 4 alias; fl is {undef, trap}
   task automatic acc(input logic w, input logic [1:0] el, input int r, input logic [63:0] d, input logic [1:0] fl);
      @(posedge mclk);
      #1 cur_el = el;
      req = '{1'b1, w, ENC_OP0, op1s[r], ENC_CRN, crm_use, (r == 3) ? ENC_OP2_S2 : ENC_OP2_MAIN, d};
      @(posedge mclk);
      #1 req.valid = 1'b0;
      rd = rdata;
      chk_word({61'h0, rv, ru, rt}, {61'h0, 1'b1, fl});
   endtask
   task automatic rdchk(input int r, input logic [63:0] exp);
      acc(1'b0, EL3, r, 64'h0, 2'h0);
      chk_word(rd, exp);
   endtask
   task automatic wchk(input logic [1:0] el, input logic up, input logic s2, input logic [1:0] exp);
      u_walker.issue(el, up, s2);
      chk_attr(attrs, exp);
   endtask
   function automatic logic [1:0] pair(input logic [63:0] q, input logic up);
      return up ? {q[5] & q[13], q[4] & q[12]} : {q[1] & q[9], q[0] & q[8]};
   endfunction
   task automatic complete_run();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ==================================================================
   // Sequence of tests
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         fails++;
         complete_run();
      end
   end
   initial
   begin
      repeat (3) @(posedge mclk);
      #1 rst = 1'b0;
      for (int r = 0; r < 4; r++)
         rdchk(r, RESET_VAL);
      $display("test reset_values done");
      for (int r = 0; r < 4; r++)
      begin
         acc(1'b1, EL3, r, '1, 2'h0);
         rdchk(r, (r < 2) ? DUAL_MASK : SINGLE_MASK);
      end
      $display("test field_masks done");
      acc(1'b0, EL1, 1, 64'h0, 2'h2);
      chk_word(rd, 64'h0);
      acc(1'b1, EL2, 2, 64'h0, 2'h2);
      acc(1'b1, EL1, 3, 64'h0, 2'h2);
      acc(1'b1, EL2, 4, 64'h0, 2'h2);
      acc(1'b0, EL0, 1, 64'h0, 2'h2);
      acc(1'b1, EL0, 3, 64'h0, 2'h2);
      crm_use = 4'h6;
      acc(1'b1, EL3, 0, 64'h0, 2'h2);
      crm_use = ENC_CRM;
      rdchk(2, SINGLE_MASK);
      rdchk(3, SINGLE_MASK);
      rdchk(0, DUAL_MASK);
      $display("test refusals done");
      hm = 1'b1;
      acc(1'b1, EL2, 4, 64'h1111, 2'h0);
      rdchk(0, 64'h1111);
      acc(1'b0, EL3, 4, 64'h0, 2'h0);
      chk_word(rd, 64'h1111);
      acc(1'b1, EL2, 0, 64'h2222, 2'h0);
      rdchk(1, 64'h2222);
      trp = 1'b1;
      acc(1'b1, EL2, 4, 64'h0, 2'h1);
      acc(1'b1, EL1, 0, 64'h0, 2'h1);
      trp = 1'b0;
      hm = 1'b0;
      rdchk(0, 64'h1111);
      $display("test alias_and_traps done");
      foreach (pats[i])
      begin
         acc(1'b1, EL1, 0, pats[i], 2'h0);
         acc(1'b1, EL2, 1, ~pats[i], 2'h0);
         acc(1'b1, EL3, 2, pats[i], 2'h0);
         acc(1'b1, EL2, 3, ~pats[i], 2'h0);
         wchk(EL1, 1'b1, 1'b0, pair(pats[i], 1'b1));
         wchk(EL0, 1'b0, 1'b0, pair(pats[i], 1'b0));
         wchk(EL2, 1'b1, 1'b0, pair(~pats[i], 1'b1));
         wchk(EL3, 1'b1, 1'b0, pair(pats[i], 1'b0));
         wchk(EL1, 1'b0, 1'b1, pair(~pats[i], 1'b0));
         wchk(EL2, 1'b0, 1'b1, 2'h0);
      end
      $display("test walk_attributes done");
      rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 rst = 1'b0;
      for (int r = 0; r < 4; r++)
         rdchk(r, RESET_VAL);
      wchk(EL1, 1'b1, 1'b0, 2'h0);
      $display("test mid_reset done");
      complete_run();
   end
endmodule // walk_attribute_ctrl_regs_tb_top
bind wac_top wac_assertions #(.ATTR_SUPPORT(ATTR_SUPPORT)) u_chk (.mclk(mclk), .rst(rst), .cur_el(cur_el),
   .level1_trap(level1_trap), .req(req), .rsp_valid(rsp_valid), .rsp_undef(rsp_undef), .walk(walk),
   .page_hw_attribute_bits(page_hw_attribute_bits), .walk_attr_ctrl_level1_q(walk_attr_ctrl_level1_q),
   .walk_attr_ctrl_level2_q(walk_attr_ctrl_level2_q), .walk_attr_ctrl_level3_q(walk_attr_ctrl_level3_q),
   .stage2_walk_attr_ctrl_q(stage2_walk_attr_ctrl_q));
`default_nettype wire
